// [common/vdc_defines.svh]
`ifndef VDC_DEFINES_SVH
`define VDC_DEFINES_SVH
// setup command: family and selector nibbles of the first byte, payload marker bit, mask reset value
`define VDC_CMD_FAMILY 4'hf
`define VDC_SEL_VPS 4'h7
`define VDC_SEL_PDC_LO 4'h8
`define VDC_SEL_PDC_HI 4'h9
`define VDC_PAYLOAD_BIT 3'h7
`define VDC_MASK_RST 8'h00
// slicer modes
`define VDC_MODE_VPS 4'h0
`define VDC_MODE_PDC 4'h1
`define VDC_MODE_HDR1 4'h4
`define VDC_MODE_HDR2 4'h5
`define VDC_MODE_HDR3 4'h6
`define VDC_MODE_HDR4 4'h7
`define VDC_MODE_STS1 4'h8
`define VDC_MODE_STS2 4'h9
`define VDC_MODE_STS3 4'ha
`define VDC_MODE_STS4 4'hb
`define VDC_MODE_PULSE 4'hc
// received byte numbers
`define VDC_VPS_B5 6'h05
`define VDC_VPS_B11 6'h0b
`define VDC_VPS_B15 6'h0f
`define VDC_PDC_B13 6'h0d
`define VDC_PDC_B14 6'h0e
`define VDC_PDC_B15 6'h0f
`define VDC_PDC_B19 6'h13
`define VDC_PDC_B20 6'h14
`define VDC_PDC_B21 6'h15
`define VDC_PDC_B25 6'h19
`define VDC_PULSE_LO 6'h01
`define VDC_PULSE_HI 6'h02
// first byte of each header / status window, window lengths, low mask bit count
`define VDC_HDR1_BASE 6'h26
`define VDC_HDR2_BASE 6'h16
`define VDC_HDR3_BASE 6'h1e
`define VDC_HDR4_BASE 6'h0e
`define VDC_STS1_BASE 6'h1a
`define VDC_STS2_BASE 6'h24
`define VDC_HDR_SPAN 6'h08
`define VDC_STS_SPAN 6'h0a
`define VDC_LO_BITS 6'h07
// output byte positions, fixed patterns, word update delay and link bit slots
`define VDC_IDX_FIRST 4'h1
`define VDC_IDX_LAST 4'hf
`define VDC_VPS_DATA_N 4'h6
`define VDC_VPS_STOP_IDX 4'h7
`define VDC_VPS_FLAG_IDX 4'h8
`define VDC_PDC_N 4'hd
`define VDC_FILL 8'hff
`define VDC_VPS_STOP 8'hfe
`define VDC_UPD_CYC 2'h2
`define VDC_ACK_SLOT 4'h8
`define VDC_LAST_BIT 4'h7
`endif

// [common/vdc_pkg.sv]
package vdc_pkg;
  typedef enum logic [1:0] {CMD_IDLE, CMD_VPS, CMD_PDC_LO, CMD_PDC_HI} vdc_cmd_st_t;
  // command byte from the serial receiver
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } vdc_cmd_t;
  // one received line byte from the slicer, with its check result
  typedef struct packed {
    logic valid;
    logic [5:0] idx;
    logic [7:0] data;
    logic err;
  } vdc_rx_t;
  // serial data pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } vdc_sda_t;
endpackage : vdc_pkg

// [design/vdc_store.sv]
`timescale 1ns/1ps
// captured line bytes, one word per received byte number
module vdc_store #(
  parameter int W = 8,
  parameter int AW = 6
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // array has no reset; it is only read after a line was captured
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule : vdc_store

// [design/vdc_format.sv]
// Functional notes
// RULE1: first byte 0xf? selects family; low nibble picks which mask command follows.
// RULE2: second byte has bit 7 zero (bit 6 too when unused); marks payload.
// RULE3: vps mask bit 1 governs byte 11, bit 0 byte 5; zero checks, one writes.
// RULE4: pdc low mask bits 6..0 govern received bytes 19..13; zero checks.
// RULE5: pdc high mask bits 5..0 govern received bytes 25..20; zero checks.
// RULE6: header and status modes reuse mask bits for odd parity on shifted bytes.
// RULE7: hold or write meaning follows the global error mode bit.
// RULE8: reset pin clears every mask bit, so all checks start enabled.
// RULE9: output starts with byte one, each byte sent bit 7 first.
// RULE10: positions without data or flag read as one.
// RULE11: pdc format 1 packs bytes 15..20, 21, 13, 14, 22..25, bit reversed.
// RULE12: vps packs 11..14, 5, 15 reversed, then 0xfe, then six flags.
// RULE13: header modes 1 and 3 send bytes 38..45 or 30..37, then flags.
// RULE14: header modes 2 and 4 send bytes 22..29 or 14..21, then flags.
// RULE15: status modes 1 and 3 send bytes 26..35, then two flag bytes.
// RULE16: status modes 2 and 4 send bytes 36..45, then two flag bytes.
// RULE17: pulse mode sends code bits 0..7, then bits 8..13 and two zeros.
// RULE18: error mode zero writes only clean checked bytes; one writes everything. In mode zero the code also writes erroneous bytes whose mask bit is one.
// RULE19: each acknowledged read byte advances to the next output byte.
`timescale 1ns/1ps
`include "vdc_defines.svh"
module vdc_format (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_clk,
  input vdc_pkg::vdc_cmd_t cmd,
  input vdc_pkg::vdc_rx_t rx,
  input wire logic [3:0] slicer_mode,
  input wire logic global_error_mode,
  input wire logic rd_arm,
  input wire logic rd_begin,
  input wire logic sda_in,
  output vdc_pkg::vdc_sda_t sda,
  output logic [7:0] vps_biphase_check_mask,
  output logic [7:0] pdc_hamming_check_mask_low,
  output logic [7:0] pdc_hamming_check_mask_high
);
  import vdc_pkg::*;

  vdc_cmd_st_t st_r, st_nxt;
  logic [7:0] vps_r, pdc_lo_r, pdc_hi_r;
  logic pay;
  logic chk_off, mem_we;
  logic is_hdr, is_sts;
  logic [5:0] base, span, rel;
  logic [63:0] err_r, err_sh;
  logic [5:0] raddr;
  logic [7:0] rdata, rev, flags, word_nxt, word_r;
  logic [3:0] idx_r;
  logic [1:0] upd_r;
  logic req_s1, req_s2, req_s3, adv;
  logic req_r, active_r, oe_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;

  // first-byte decode; a byte with bit 7 set always restarts decoding
  always_comb
  begin
    st_nxt = st_r;
    if (cmd.valid)
    begin
      if (st_r == CMD_IDLE || cmd.data[`VDC_PAYLOAD_BIT])
      begin
        st_nxt = CMD_IDLE;
        if (cmd.data[7:4] == `VDC_CMD_FAMILY) // RULE1
        begin
          case (cmd.data[3:0])
            `VDC_SEL_VPS: st_nxt = CMD_VPS;
            `VDC_SEL_PDC_LO: st_nxt = CMD_PDC_LO;
            `VDC_SEL_PDC_HI: st_nxt = CMD_PDC_HI;
            default: st_nxt = CMD_IDLE;
          endcase
        end
      end
      else
      begin
        st_nxt = CMD_IDLE;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= CMD_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // payload byte: zero in bit 7 while a command is pending
  assign pay = cmd.valid && st_r != CMD_IDLE && !cmd.data[`VDC_PAYLOAD_BIT]; // RULE2

  // mask registers; unused upper bits are forced to zero on write
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vps_r <= `VDC_MASK_RST; // RULE8
      pdc_lo_r <= `VDC_MASK_RST;
      pdc_hi_r <= `VDC_MASK_RST;
    end
    else if (pay)
    begin
      unique case (st_r)
        CMD_VPS: vps_r <= {2'h0, cmd.data[5:0]}; // RULE3
        CMD_PDC_LO: pdc_lo_r <= {1'h0, cmd.data[6:0]}; // RULE4
        CMD_PDC_HI: pdc_hi_r <= {2'h0, cmd.data[5:0]}; // RULE5
        CMD_IDLE: vps_r <= vps_r;
      endcase
    end
  end

  assign vps_biphase_check_mask = vps_r;
  assign pdc_hamming_check_mask_low = pdc_lo_r;
  assign pdc_hamming_check_mask_high = pdc_hi_r;

  // window of the header and status modes
  always_comb
  begin
    is_hdr = 1'b1;
    is_sts = 1'b0;
    span = `VDC_HDR_SPAN;
    unique case (slicer_mode)
      `VDC_MODE_HDR1: base = `VDC_HDR1_BASE;
      `VDC_MODE_HDR2: base = `VDC_HDR2_BASE;
      `VDC_MODE_HDR3: base = `VDC_HDR3_BASE;
      `VDC_MODE_HDR4: base = `VDC_HDR4_BASE;
      `VDC_MODE_STS1, `VDC_MODE_STS3:
      begin
        base = `VDC_STS1_BASE;
        is_sts = 1'b1;
      end
      `VDC_MODE_STS2, `VDC_MODE_STS4:
      begin
        base = `VDC_STS2_BASE;
        is_sts = 1'b1;
      end
      default:
      begin
        base = '0;
        is_hdr = 1'b0;
      end
    endcase
    if (is_sts)
    begin
      is_hdr = 1'b0;
      span = `VDC_STS_SPAN;
    end
  end

  // which mask bit, if any, switches off the check of the incoming byte
  assign rel = rx.idx - base;
  always_comb
  begin
    chk_off = 1'b0;
    if (slicer_mode == `VDC_MODE_VPS)
    begin
      if (rx.idx == `VDC_VPS_B11)
        chk_off = vps_r[1]; // RULE3
      else if (rx.idx == `VDC_VPS_B5)
        chk_off = vps_r[0];
    end
    else if (slicer_mode == `VDC_MODE_PDC)
    begin
      if (rx.idx >= `VDC_PDC_B13 && rx.idx <= `VDC_PDC_B19)
        chk_off = pdc_lo_r[3'(rx.idx - `VDC_PDC_B13)]; // RULE4
      else if (rx.idx >= `VDC_PDC_B20 && rx.idx <= `VDC_PDC_B25)
        chk_off = pdc_hi_r[3'(rx.idx - `VDC_PDC_B20)]; // RULE5
    end
    else if ((is_hdr || is_sts) && rx.idx >= base && rel < span)
    begin
      if (rel < `VDC_LO_BITS)
        chk_off = pdc_lo_r[3'(rel)]; // RULE6
      else
        chk_off = pdc_hi_r[3'(rel - `VDC_LO_BITS)];
    end
  end

  // checked bytes with an error are held unless the error mode writes all
  assign mem_we = rx.valid && (global_error_mode || chk_off || !rx.err); // RULE7 RULE18

  // error flags are kept whatever the write decision, for the flag bytes
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_r <= '0;
    end
    else if (rx.valid)
    begin
      err_r[rx.idx] <= rx.err;
    end
  end

  // source byte number of the current output byte
  always_comb
  begin
    raddr = base + 6'(idx_r) - 6'h01;
    unique case (slicer_mode)
      `VDC_MODE_VPS:
      begin
        if (idx_r == `VDC_VPS_DATA_N - 4'h1)
          raddr = `VDC_VPS_B5;
        else if (idx_r == `VDC_VPS_DATA_N)
          raddr = `VDC_VPS_B15;
        else
          raddr = `VDC_VPS_B11 + 6'(idx_r) - 6'h01;
      end
      `VDC_MODE_PDC:
      begin
        if (idx_r <= `VDC_VPS_DATA_N)
          raddr = `VDC_PDC_B15 + 6'(idx_r) - 6'h01;
        else if (idx_r == `VDC_VPS_STOP_IDX)
          raddr = `VDC_PDC_B21;
        else if (idx_r == `VDC_VPS_FLAG_IDX)
          raddr = `VDC_PDC_B13;
        else if (idx_r == `VDC_VPS_FLAG_IDX + 4'h1)
          raddr = `VDC_PDC_B14;
        else
          raddr = `VDC_PDC_B21 + 6'(idx_r) - 6'h09;
      end
      `VDC_MODE_PULSE: raddr = idx_r[1] ? `VDC_PULSE_HI : `VDC_PULSE_LO;
      default: raddr = base + 6'(idx_r) - 6'h01;
    endcase
  end

  vdc_store #(
    .W(8),
    .AW(6)
  ) u_store (
    .clock(clock),
    .rst_b(rst_b),
    .we(mem_we),
    .waddr(rx.idx),
    .wdata(rx.data),
    .raddr(raddr),
    .rdata(rdata)
  );

  // received bit 0 goes out first, so every data byte is reversed
  assign err_sh = err_r >> base;
  for (genvar i = 0; i < 8; i++)
  begin : g_rev
    assign rev[i] = rdata[7-i];
    assign flags[7-i] = err_sh[i];
  end

  // output byte assembly; anything not listed reads as all ones
  always_comb
  begin
    word_nxt = `VDC_FILL; // RULE10
    unique case (slicer_mode)
      `VDC_MODE_VPS:
      begin
        if (idx_r >= `VDC_IDX_FIRST && idx_r <= `VDC_VPS_DATA_N)
          word_nxt = rev; // RULE12
        else if (idx_r == `VDC_VPS_STOP_IDX)
          word_nxt = `VDC_VPS_STOP;
        else if (idx_r == `VDC_VPS_FLAG_IDX)
          word_nxt = {err_r[11], err_r[12], err_r[13], err_r[14], err_r[5], err_r[15], 2'h0};
      end
      `VDC_MODE_PDC:
      begin
        if (idx_r >= `VDC_IDX_FIRST && idx_r <= `VDC_PDC_N)
          word_nxt = rev; // RULE11
      end
      `VDC_MODE_HDR1, `VDC_MODE_HDR2, `VDC_MODE_HDR3, `VDC_MODE_HDR4:
      begin
        if (idx_r >= `VDC_IDX_FIRST && idx_r <= 4'(`VDC_HDR_SPAN))
          word_nxt = rev; // RULE13 RULE14
        else if (idx_r == 4'(`VDC_HDR_SPAN) + 4'h1)
          word_nxt = flags;
      end
      `VDC_MODE_STS1, `VDC_MODE_STS2, `VDC_MODE_STS3, `VDC_MODE_STS4:
      begin
        if (idx_r >= `VDC_IDX_FIRST && idx_r <= 4'(`VDC_STS_SPAN))
          word_nxt = rev; // RULE15 RULE16
        else if (idx_r == 4'(`VDC_STS_SPAN) + 4'h1)
          word_nxt = flags;
        else if (idx_r == 4'(`VDC_STS_SPAN) + 4'h2)
          word_nxt = {err_sh[8], err_sh[9], 6'h00};
      end
      `VDC_MODE_PULSE:
      begin
        if (idx_r == `VDC_IDX_FIRST)
          word_nxt = rev; // RULE17
        else if (idx_r == `VDC_IDX_FIRST + 4'h1)
          word_nxt = {rev[7:2], 2'h0};
      end
      default: word_nxt = `VDC_FILL;
    endcase
  end

  // request toggle from the link, two flops then an edge detector
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end
    else
    begin
      req_s1 <= req_r;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end
  assign adv = req_s2 ^ req_s3;

  // output byte pointer; saturates so a long read keeps returning ones
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idx_r <= `VDC_IDX_FIRST;
      upd_r <= '0;
    end
    else if (rd_arm)
    begin
      idx_r <= `VDC_IDX_FIRST; // RULE9
      upd_r <= `VDC_UPD_CYC;
    end
    else if (adv)
    begin
      if (idx_r != `VDC_IDX_LAST)
        idx_r <= idx_r + 4'h1; // RULE19
      upd_r <= `VDC_UPD_CYC;
    end
    else if (upd_r != 2'h0)
    begin
      upd_r <= upd_r - 2'h1;
    end
  end

  // word held stable between updates, since the link samples it raw
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_r <= `VDC_FILL;
    end
    else if (upd_r == 2'h1)
    begin
      word_r <= word_nxt;
    end
  end

  // link side: shift on falling clock, ack slot sampled on its falling edge
  always_ff @(negedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active_r <= 1'b0;
      bit_r <= '0;
      sh_r <= `VDC_FILL;
      oe_r <= 1'b0;
      req_r <= 1'b0;
    end
    else if (rd_begin)
    begin
      active_r <= 1'b1;
      bit_r <= '0;
      sh_r <= word_r; // RULE9
      oe_r <= 1'b1;
      req_r <= !req_r;
    end
    else if (active_r)
    begin
      if (bit_r == `VDC_ACK_SLOT)
      begin
        if (!sda_in)
        begin
          bit_r <= '0;
          sh_r <= word_r; // RULE19
          oe_r <= 1'b1;
          req_r <= !req_r;
        end
        else
        begin
          active_r <= 1'b0; // no ack ends the read
        end
      end
      else if (bit_r == `VDC_LAST_BIT)
      begin
        bit_r <= `VDC_ACK_SLOT;
        oe_r <= 1'b0;
      end
      else
      begin
        bit_r <= bit_r + 4'h1;
        sh_r <= {sh_r[6:0], 1'b1}; // RULE9
      end
    end
  end

  assign sda.out = sh_r[7];
  assign sda.oe = oe_r;

  property p_first_decode;
    @(posedge clock) disable iff (!rst_b)
    (st_r == CMD_IDLE && cmd.valid && cmd.data == {`VDC_CMD_FAMILY, `VDC_SEL_PDC_HI})
    |=> st_r == CMD_PDC_HI;
  endproperty
  a_first_decode: assert property (p_first_decode) // RULE1
    else $error("high mask command not selected");

  property p_flag_byte_ignored;
    @(posedge clock) disable iff (!rst_b)
    (st_r == CMD_VPS && cmd.valid && cmd.data[7]) |=> $stable(vps_r);
  endproperty
  a_flag_byte_ignored: assert property (p_flag_byte_ignored) // RULE2
    else $error("byte with bit 7 set stored as mask");

  property p_vps_store;
    @(posedge clock) disable iff (!rst_b)
    (st_r == CMD_VPS && cmd.valid && !cmd.data[7]) |=> st_r == CMD_IDLE ##0
    vps_r[5:0] == $past(cmd.data[5:0]) && !vps_r[7];
  endproperty
  a_vps_store: assert property (p_vps_store) // RULE3
    else $error("vps mask not stored");

  property p_lo_store;
    @(posedge clock) disable iff (!rst_b)
    (st_r == CMD_PDC_LO && cmd.valid && !cmd.data[7]) |=> pdc_lo_r[6:0] == $past(cmd.data[6:0]);
  endproperty
  a_lo_store: assert property (p_lo_store) // RULE4
    else $error("pdc low mask not stored");

  property p_hi_hold;
    @(posedge clock) disable iff (!rst_b)
    !(st_r == CMD_PDC_HI && cmd.valid && !cmd.data[7]) |=> $stable(pdc_hi_r);
  endproperty
  a_hi_hold: assert property (p_hi_hold) // RULE5
    else $error("pdc high mask changed without command");

  property p_hold_error;
    @(posedge clock) disable iff (!rst_b)
    (rx.valid && rx.err && !global_error_mode && !chk_off) |-> !mem_we;
  endproperty
  a_hold_error: assert property (p_hold_error) // RULE7
    else $error("erroneous checked byte written");

  property p_write_all;
    @(posedge clock) disable iff (!rst_b)
    (rx.valid && global_error_mode) |-> mem_we;
  endproperty
  a_write_all: assert property (p_write_all) // RULE18
    else $error("byte not written in write-all mode");

  property p_vps_stop;
    @(posedge clock) disable iff (!rst_b)
    (upd_r == 2'h1 && slicer_mode == `VDC_MODE_VPS && idx_r == `VDC_VPS_STOP_IDX)
    |=> word_r == `VDC_VPS_STOP;
  endproperty
  a_vps_stop: assert property (p_vps_stop) // RULE12
    else $error("vps byte seven wrong");

  property p_fill;
    @(posedge clock) disable iff (!rst_b)
    (upd_r == 2'h1 && idx_r > `VDC_PDC_N) |=> word_r == `VDC_FILL;
  endproperty
  a_fill: assert property (p_fill) // RULE10
    else $error("unused output byte not all ones");

  property p_advance;
    @(posedge clock) disable iff (!rst_b)
    (adv && !rd_arm && idx_r < `VDC_IDX_LAST) |=> idx_r == $past(idx_r) + 4'h1 ##2 upd_r == 2'h0;
  endproperty
  a_advance: assert property (p_advance) // RULE19
    else $error("output pointer did not advance");

  property p_msb_first;
    @(negedge scl_clk) disable iff (!rst_b)
    (active_r && !rd_begin && bit_r < `VDC_LAST_BIT) |=> sh_r[7] == $past(sh_r[6]) && oe_r;
  endproperty
  a_msb_first: assert property (p_msb_first) // RULE9
    else $error("data not shifted msb first");

  property p_ack_load;
    @(negedge scl_clk) disable iff (!rst_b)
    (active_r && !rd_begin && bit_r == `VDC_ACK_SLOT && !sda_in)
    |=> bit_r == 4'h0 && oe_r && req_r != $past(req_r);
  endproperty
  a_ack_load: assert property (p_ack_load) // RULE19
    else $error("ack did not start next byte");
endmodule : vdc_format

// [dv/vdc_host_model.sv]
`timescale 1ns/1ps
// host end of the read link: clocks bytes out of the device and acks them
module vdc_host_model #(
  parameter int SCL_HALF = 6
) (
  output logic scl_clk,
  output logic rd_begin,
  output logic host_sda,
  input vdc_pkg::vdc_sda_t sda
);
  import vdc_pkg::*;
  logic [7:0] got [1:15];
  logic line;
  // pull-up wins whenever the device lets go of the data line
  assign line = sda.oe ? sda.out : 1'b1;
  // link clock stands high between frames
  initial
  begin
    scl_clk = 1'b1;
    rd_begin = 1'b0;
    host_sda = 1'b1;
  end
  // 12 ns link period; nine periods per byte leave the device time to fetch the next word
  task automatic read_frame(input int n);
    rd_begin = 1'b1;
    #(SCL_HALF) scl_clk = 1'b0;
    #1 rd_begin = 1'b0;
    for (int b = 1; b <= n; b++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        #(SCL_HALF - 1) scl_clk = 1'b1;
        got[b][i] = line;
        #(SCL_HALF) scl_clk = 1'b0;
        #1;
      end
      // ack every byte but the last, which ends the read
      host_sda = (b < n) ? 1'b0 : 1'b1;
      #(SCL_HALF - 1) scl_clk = 1'b1;
      #(SCL_HALF) scl_clk = 1'b0;
      #1 host_sda = 1'b1;
    end
    #(SCL_HALF - 1) scl_clk = 1'b1;
  endtask : read_frame
endmodule : vdc_host_model

// [dv/vdc_format_tb_top.sv]
`timescale 1ns/1ps
module vdc_format_tb_top;
  import vdc_pkg::*;
  localparam int PDC_SRC [1:13] = '{15, 16, 17, 18, 19, 20, 21, 13, 14, 22, 23, 24, 25};
  logic clock, rst_b, global_error_mode, rd_arm;
  logic [3:0] slicer_mode;
  logic scl_clk, rd_begin, host_sda, sda_in;
  vdc_cmd_t cmd;
  vdc_rx_t rx;
  vdc_sda_t sda;
  logic [7:0] vps_mask, pdc_lo, pdc_hi, exp_vps, exp_lo, exp_hi;
  logic [7:0] mem [0:63];
  logic flg [0:63];
  logic [3:0] modes [11] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  int mismatches, checked, seed;
  // wired-and of host and device on the data line
  assign sda_in = host_sda & (sda.oe ? sda.out : 1'b1);
  vdc_format dut (.clock(clock), .rst_b(rst_b), .scl_clk(scl_clk), .cmd(cmd), .rx(rx),
    .slicer_mode(slicer_mode), .global_error_mode(global_error_mode), .rd_arm(rd_arm),
    .rd_begin(rd_begin), .sda_in(sda_in), .sda(sda), .vps_biphase_check_mask(vps_mask),
    .pdc_hamming_check_mask_low(pdc_lo), .pdc_hamming_check_mask_high(pdc_hi));
  vdc_host_model host (.scl_clk(scl_clk), .rd_begin(rd_begin), .host_sda(host_sda), .sda(sda));
  // system clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++)
      rev[i] = x[7 - i];
  endfunction : rev
  function automatic int base_of(input logic [3:0] m);
    case (m)
      4'h1: return 13;
      4'h4: return 38;
      4'h5: return 22;
      4'h6: return 30;
      4'h7: return 14;
      4'h8, 4'ha: return 26;
      4'h9, 4'hb: return 36;
      default: return 0;
    endcase
  endfunction : base_of
  function automatic int span_of(input logic [3:0] m);
    return (m == 4'h1) ? 13 : (m < 4'h8) ? 8 : 10;
  endfunction : span_of
  // one when the byte is written even with an error; unmasked bytes count as checked
  function automatic logic chk_off(input logic [3:0] m, input int idx);
    int k;
    k = idx - base_of(m);
    if (m == 4'h0)
      return (idx == 11) ? exp_vps[1] : (idx == 5 && exp_vps[0]);
    if (m == 4'hc || k < 0 || k >= span_of(m))
      return 1'b0;
    return (k < 7) ? exp_lo[k] : exp_hi[k - 7];
  endfunction : chk_off
  function automatic logic [7:0] flags8(input int b);
    for (int i = 0; i < 8; i++)
      flags8[7 - i] = flg[b + i];
  endfunction : flags8
  // expected output byte n of a read in mode m, fill ones elsewhere
  function automatic logic [7:0] exp_byte(input logic [3:0] m, input int n);
    int b;
    logic [7:0] f;
    b = base_of(m);
    f = 8'hff;
    if (m == 4'h0 && n <= 6)
      f = rev(mem[n <= 4 ? 10 + n : (n == 5 ? 5 : 15)]);
    else if (m == 4'h0 && n == 7)
      f = 8'hfe;
    else if (m == 4'h0 && n == 8)
      f = {flg[11], flg[12], flg[13], flg[14], flg[5], flg[15], 2'b00};
    else if (m == 4'h1 && n <= 13)
      f = rev(mem[PDC_SRC[n]]);
    else if (m == 4'hc && n <= 2)
      f = rev(mem[n]) & ((n == 2) ? 8'hfc : 8'hff);
    else if (m >= 4'h4 && m <= 4'hb && n <= span_of(m))
      f = rev(mem[b + n - 1]);
    else if (m >= 4'h4 && m <= 4'hb && n == span_of(m) + 1)
      f = flags8(b);
    else if (m >= 4'h8 && m <= 4'hb && n == 12)
      f = {flg[b + 8], flg[b + 9], 6'h00};
    return f;
  endfunction : exp_byte
  task automatic put_cmd(input logic [7:0] b);
    @(posedge clock);
    #1 cmd = '{1'b1, b};
    @(posedge clock);
    #1 cmd.valid = 1'b0;
  endtask : put_cmd
  // all three mask commands with random payloads, top bits held at zero
  task automatic set_masks();
    exp_vps = $random(seed) & 8'h3f;
    exp_lo = $random(seed) & 8'h7f;
    exp_hi = $random(seed) & 8'h3f;
    put_cmd(8'hf7);
    put_cmd(exp_vps);
    put_cmd(8'hf8);
    put_cmd(exp_lo);
    put_cmd(8'hf9);
    put_cmd(exp_hi);
    repeat (2) @(posedge clock);
    check("vps mask", vps_mask, exp_vps);
    check("pdc mask low", pdc_lo, exp_lo);
    check("pdc mask high", pdc_hi, exp_hi);
  endtask : set_masks
  // slicer byte; shadow store follows the hold or write decision
  task automatic rx_put(input int idx, input logic [7:0] d, input logic e);
    @(posedge clock);
    #1 rx = '{1'b1, idx[5:0], d, e};
    flg[idx] = e;
    if (!e || global_error_mode || chk_off(slicer_mode, idx))
      mem[idx] = d;
    @(posedge clock);
    #1 rx.valid = 1'b0;
  endtask : rx_put
  task automatic read_out(input logic [3:0] m);
    @(posedge clock);
    #1 rd_arm = 1'b1;
    @(posedge clock);
    #1 rd_arm = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    host.read_frame(15);
    @(posedge clock);
    #1;
    for (int n = 1; n <= 15; n++)
      check("output byte", host.got[n], exp_byte(m, n));
  endtask : read_out
  // watchdog against a hung run
  initial
  begin
    repeat (90000) @(posedge clock);
    mismatches++;
    final_report();
  end
  // main sequence
  initial
  begin
    seed = 87204;
    mismatches = 0;
    checked = 0;
    rst_b = 1'b0;
    cmd = '0;
    rx = '0;
    slicer_mode = 4'h0;
    global_error_mode = 1'b0;
    rd_arm = 1'b0;
    repeat (6) @(posedge clock);
    #1 rst_b = 1'b1;
    check("vps mask", vps_mask, 8'h00);
    check("pdc mask low", pdc_lo, 8'h00);
    // foreign first byte, then a command cut short by a fresh first byte
    put_cmd(8'he7);
    put_cmd(8'h03);
    put_cmd(8'hf7);
    put_cmd(8'hf8);
    put_cmd(8'h05);
    repeat (2) @(posedge clock);
    check("vps mask", vps_mask, 8'h00);
    check("pdc mask low", pdc_lo, 8'h05);
    // fill the store cleanly so every later expectation is known
    global_error_mode = 1'b1;
    for (int i = 0; i <= 45; i++)
      rx_put(i, $random(seed), 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      for (int j = 0; j < 11; j++)
      begin
        slicer_mode = modes[j];
        global_error_mode = p[0];
        set_masks();
        for (int i = 1; i <= 45; i++)
          rx_put(i, $random(seed), $random(seed) & 1);
        read_out(modes[j]);
      end
    end
    // second reset in mid-run clears the masks and frees the line
    @(posedge clock);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clock);
    check("vps mask", vps_mask, 8'h00);
    check("pdc mask high", pdc_hi, 8'h00);
    check("drive enable", {7'h00, sda.oe}, 8'h00);
    #1 rst_b = 1'b1;
    // a command right after release must still be taken
    put_cmd(8'hf9);
    put_cmd(8'h2a);
    repeat (2) @(posedge clock);
    check("pdc mask high", pdc_hi, 8'h2a);
    final_report();
  end
endmodule : vdc_format_tb_top
